//--- core/agc_pkg.sv
// package: register map, reset values and carriers of the agc decision
package agc_pkg;

// ==========================================================================
// register word indices, byte address = 4 * index
localparam logic [5:0] IDX_CTRL   = 6'h00;
localparam logic [5:0] IDX_PERIOD = 6'h01;
localparam logic [5:0] IDX_TDD    = 6'h02;
localparam logic [5:0] IDX_PWR    = 6'h03;
localparam logic [5:0] IDX_PEAK   = 6'h04;
localparam logic [5:0] IDX_STEP   = 6'h05;
localparam logic [5:0] IDX_HWIN   = 6'h06;
localparam logic [5:0] IDX_HLVA   = 6'h07;
localparam logic [5:0] IDX_HLVB   = 6'h08;
localparam logic [5:0] IDX_HCNT   = 6'h09;
localparam logic [5:0] IDX_RECOV  = 6'h0a;
localparam logic [5:0] IDX_PINSEL = 6'h0b;
localparam logic [5:0] IDX_GAIN   = 6'h0c;
localparam logic [5:0] IDX_STATUS = 6'h0d;
localparam logic [5:0] NREG       = 6'h0d;

// ==========================================================================
// reset values
localparam logic [31:0] RST_CTRL   = 32'h0000_0005;
localparam logic [31:0] RST_PERIOD = 32'h0000_2d00;
localparam logic [31:0] RST_TDD    = 32'h0000_0000;
localparam logic [31:0] RST_PWR    = 32'h0004_2007;
localparam logic [31:0] RST_PEAK   = 32'h0603_054c;
localparam logic [31:0] RST_STEP   = 32'h0c41_0802;
localparam logic [31:0] RST_HWIN   = 32'h0000_0009;
localparam logic [31:0] RST_HLVA   = 32'h0cbd_16c2;
localparam logic [31:0] RST_HLVB   = 32'h0729_e026;
localparam logic [31:0] RST_HCNT   = 32'h0303_0306;
localparam logic [31:0] RST_RECOV  = 32'h0102_0032;
localparam logic [31:0] RST_PINSEL = 32'h0000_0000;
localparam logic [31:0] RST_GAIN   = 32'h0000_ffbb;
localparam logic [7:0]  GAIN_START = 8'hff;
localparam logic [12:0][31:0] RST_REGS = {RST_GAIN, RST_PINSEL, RST_RECOV,
    RST_HCNT, RST_HLVB, RST_HLVA, RST_HWIN, RST_STEP, RST_PEAK, RST_PWR,
    RST_TDD, RST_PERIOD, RST_CTRL};

// ==========================================================================
// register layouts
typedef struct packed {
    logic [25:0] rsv;
    logic        tddOn;
    logic        blockInc;
    logic        halfMeasure;
    logic        halfOn;
    logic        fastOn;
    logic        peakMode;
} agc_ctrl_t;

typedef struct packed {
    logic [10:0] rsv;
    logic [4:0]  largeStep;
    logic [4:0]  smallStep;
    logic [3:0]  outerOffset;
    logic [6:0]  stableLevel;
} agc_pwr_t;

typedef struct packed {
    logic [7:0] upperCount;
    logic [7:0] lowerCount;
    logic [3:0] rsv;
    logic [5:0] upperLevel;
    logic [5:0] lowerLevel;
} agc_peak_t;

typedef struct packed {
    logic [1:0] rsv;
    logic [4:0] halfLowStep;
    logic [4:0] halfMidStep;
    logic [4:0] halfTopStep;
    logic [4:0] halfAttack;
    logic [4:0] pkRecovery;
    logic [4:0] pkAttack;
} agc_step_t;

typedef struct packed {
    logic [24:0] rsv;
    logic [3:0]  sampleCount;
    logic [2:0]  windowCycles;
} agc_hwin_t;

typedef struct packed {
    logic [3:0]  rsv;
    logic [13:0] hiPart;
    logic [13:0] loPart;
} agc_hlv_t;

typedef struct packed {
    logic [7:0] lowCount;
    logic [7:0] midCount;
    logic [7:0] topCount;
    logic [7:0] upperCount;
} agc_hcnt_t;

typedef struct packed {
    logic [3:0]  rsv;
    logic [5:0]  topMult;
    logic [5:0]  midMult;
    logic [15:0] baseInterval;
} agc_recov_t;

typedef struct packed {
    logic [19:0] rsv;
    logic [3:0]  upperPair;
    logic [3:0]  lowerPair;
    logic [3:0]  innerPair;
} agc_pinsel_t;

typedef struct packed {
    logic [15:0] rsv;
    logic [7:0]  maxIdx;
    logic [7:0]  minIdx;
} agc_gain_t;

// ==========================================================================
// carriers
typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
} agc_apb_req_t;

typedef struct packed {
    logic               valid;
    logic signed [15:0] i;
    logic signed [15:0] q;
} agc_iq_t;

typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
} agc_pins_t;

endpackage

//--- core/agc_halfband_det.sv
// halfband overload detector: per-window sample counting on four levels
`timescale 1ns/10ps
module agc_halfband_det (
    input  wire logic             clock,     // agc clock
    input  wire logic             rst,       // async reset, high
    input  wire logic             clear,     // restart detector
    input  wire agc_pkg::agc_iq_t iq,        // halfband output samples
    input  wire logic             measSel,   // 1 power, 0 peak magnitude
    input  wire logic [2:0]       window,    // window length minus one
    input  wire logic [3:0]       needCount, // samples for one overload
    input  wire logic [3:0][13:0] levels,    // upper, top, mid, low
    output logic      [3:0]       overload   // one-cycle overload pulses
);

typedef struct packed {
    logic [2:0]      win;
    logic [3:0][3:0] hits;
    logic [3:0]      ovl;
} agc_hb_st_t;

agc_hb_st_t  q;
agc_hb_st_t  d;
logic [31:0] sq;
logic [15:0] ai;
logic [15:0] aq;
logic [13:0] mag;

always_comb begin
    d = q;
    d.ovl = 4'h0;
    ai = iq.i[15] ? 16'(-iq.i) : iq.i;
    aq = iq.q[15] ? 16'(-iq.q) : iq.q;
    sq = iq.i * iq.i + iq.q * iq.q;
    mag = measSel ? sq[31:18] : ((ai > aq) ? ai[15:2] : aq[15:2]);
    if (clear) begin
        d.win = 3'h0;
        d.hits = '0;
    end else if (iq.valid) begin
        for (int k = 0; k < 4; k++) begin
            if (mag > levels[k] && q.hits[k] != 4'hf) begin
                d.hits[k] = q.hits[k] + 4'h1;
            end
        end
        if (q.win == window) begin
            for (int k = 0; k < 4; k++) begin
                d.ovl[k] = d.hits[k] >= needCount;
            end
            d.hits = '0;
            d.win = 3'h0;
        end else begin
            d.win = q.win + 3'h1;
        end
    end
end

always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
        q <= '0;
    end else begin
        q <= d;
    end
end

assign overload = q.ovl;

default clocking @(posedge clock); endclocking
default disable iff (rst);

a_window_end: assert property (q.ovl != 4'h0 |-> $past(iq.valid) &&
    $past(q.win) == $past(window) && !$past(clear))
    else $error("overload outside window end");

a_window_restart: assert property ((iq.valid && !clear &&
    q.win == window) |=> q.hits == '0 && q.win == 3'h0)
    else $error("window counters not restarted");

endmodule

//--- core/agc_decision.sv
// receive agc decision: power, analog peak and halfband detector paths
`timescale 1ns/10ps
module agc_decision (
    input  wire logic                  clock,          // agc clock 25 MHz
    input  wire logic                  rst,            // async reset, high
    input  wire agc_pkg::agc_apb_req_t apbReq,         // apb request
    output logic [31:0]                prdata,         // apb read data
    output logic                       pready,         // apb ready
    output logic                       pslverr,        // apb error
    input  wire logic                  rxEnable,       // receiver enable pin
    input  wire logic                  peakUpperHit,   // upper crossing pin
    input  wire logic                  peakLowerHit,   // lower crossing pin
    input  wire agc_pkg::agc_iq_t      iq,             // halfband samples
    input  wire logic                  powerValid,     // power result strobe
    input  wire logic [6:0]            powerLevel,     // power, -dB
    input  wire logic [4:0]            powerUnderStep, // power raise request
    output logic [5:0]                 peakUpperLevel, // analog upper level
    output logic [5:0]                 peakLowerLevel, // analog lower level
    output logic                       powerWindow,    // power window open
    output logic [7:0]                 gainIndex,      // gain index pointer
    output logic                       gainChange,     // gain changed pulse
    output agc_pkg::agc_pins_t         gpioPins        // status pin drive
);

// ==========================================================================
// state
typedef struct packed {
    logic [12:0][31:0] regs;
    logic [31:0]       rdata;
    logic [2:0][2:0]   sync;
    logic [2:0]        filt;
    logic [21:0]       period;
    logic [15:0]       tddCnt;
    logic              tddWait;
    logic              win;
    logic [6:0]        power;
    logic              havePwr;
    logic [5:0][7:0]   cnt;
    logic [29:0]       recTmr;
    logic [7:0]        gain;
    logic              gainChg;
    logic [15:0]       gOut;
    logic [15:0]       gOe;
} agc_dec_st_t;

localparam agc_dec_st_t ST_RST = '{regs: agc_pkg::RST_REGS,
    gain: agc_pkg::GAIN_START, default: '0};

agc_dec_st_t          q;
agc_dec_st_t          d;
agc_pkg::agc_ctrl_t   ctl;
agc_pkg::agc_pwr_t    pwr;
agc_pkg::agc_peak_t   pk;
agc_pkg::agc_step_t   stp;
agc_pkg::agc_hwin_t   hwin;
agc_pkg::agc_hlv_t    hlvA;
agc_pkg::agc_hlv_t    hlvB;
agc_pkg::agc_hcnt_t   hcnt;
agc_pkg::agc_recov_t  rec;
agc_pkg::agc_pinsel_t psel;
agc_pkg::agc_gain_t   gcfg;
logic [3:0]           ovl;
logic [2:0]           rise;
logic [5:0]           hits;
logic [5:0]           flags;
logic [5:0][7:0]      need;
logic                 expire;
logic                 inner;
logic                 outer;
logic                 fast;
logic                 atk;
logic                 up;
logic [4:0]           step;
logic [29:0]          lowInt;
logic [29:0]          midInt;
logic [29:0]          topInt;
logic [5:0]           aIdx;
logic                 aAligned;
logic                 mapped;
logic [31:0]          status;
logic [31:0]          rd;
logic [31:0]          pg;

assign ctl  = q.regs[agc_pkg::IDX_CTRL];
assign pwr  = q.regs[agc_pkg::IDX_PWR];
assign pk   = q.regs[agc_pkg::IDX_PEAK];
assign stp  = q.regs[agc_pkg::IDX_STEP];
assign hwin = q.regs[agc_pkg::IDX_HWIN];
assign hlvA = q.regs[agc_pkg::IDX_HLVA];
assign hlvB = q.regs[agc_pkg::IDX_HLVB];
assign hcnt = q.regs[agc_pkg::IDX_HCNT];
assign rec  = q.regs[agc_pkg::IDX_RECOV];
assign psel = q.regs[agc_pkg::IDX_PINSEL];
assign gcfg = q.regs[agc_pkg::IDX_GAIN];

// ==========================================================================
// helpers
function automatic logic [7:0] satInc(logic [7:0] c, logic h);
    return (h && c != 8'hff) ? c + 8'h01 : c;
endfunction

function automatic logic [29:0] scaleInt(logic [5:0] m, logic [29:0] b);
    return (30'(m) + 30'h1) * b;
endfunction

function automatic logic [31:0] pinPair(logic [3:0] sel, logic lo,
                                        logic hi);
    logic [3:0] b;
    b = sel + 4'h5;
    if (sel == 4'h0 || sel > 4'h9) begin
        return 32'h0;
    end
    return {16'h0003 << b, 16'({hi, lo}) << b};
endfunction

function automatic logic [7:0] stepGain(logic [7:0] g, logic [4:0] s,
                                        logic upw, logic [7:0] lo,
                                        logic [7:0] hi);
    logic [8:0] t;
    t = upw ? {1'b0, g} + {4'h0, s} : {1'b0, g} - {4'h0, s};
    if (!upw && (t[8] || t[7:0] < lo)) begin
        return lo;
    end else if (upw && t > {1'b0, hi}) begin
        return hi;
    end
    return t[7:0];
endfunction

// ==========================================================================
// halfband detector
agc_halfband_det u_half (
    .clock     (clock),
    .rst       (rst),
    .clear     (expire || !q.filt[0] || !ctl.halfOn),
    .iq        (iq),
    .measSel   (ctl.halfMeasure),
    .window    (hwin.windowCycles),
    .needCount (hwin.sampleCount),
    .levels    ({hlvA.loPart, hlvB.loPart, hlvB.hiPart, hlvA.hiPart}),
    .overload  (ovl)
);

// ==========================================================================
// detector evaluation and decision
assign expire = q.filt[0] && q.period == 22'h0;
assign need = {hcnt.lowCount, hcnt.midCount, hcnt.topCount,
               hcnt.upperCount, pk.lowerCount, pk.upperCount};
assign inner = q.havePwr && q.power < pwr.stableLevel;
assign outer = q.havePwr &&
               {1'b0, q.power} + {4'h0, pwr.outerOffset} <
               {1'b0, pwr.stableLevel};
assign fast = ctl.fastOn && ctl.peakMode && ctl.halfOn;
assign lowInt = {14'h0, rec.baseInterval};
assign midInt = scaleInt(rec.midMult, lowInt);
assign topInt = scaleInt(rec.topMult, midInt);

always_comb begin
    for (int k = 0; k < 6; k++) begin
        flags[k] = q.cnt[k] >= need[k];
    end
    atk = 1'b0;
    up = 1'b0;
    step = 5'h0;
    if (flags[0]) begin
        atk = 1'b1;
        step = stp.pkAttack;
    end else if (ctl.halfOn && flags[2]) begin
        atk = 1'b1;
        step = stp.halfAttack;
    end else if (!ctl.peakMode && outer) begin
        atk = 1'b1;
        step = pwr.largeStep;
    end else if (!ctl.peakMode && inner) begin
        atk = 1'b1;
        step = pwr.smallStep;
    end else if (fast) begin
        if (!flags[5] && q.recTmr >= lowInt) begin
            up = 1'b1;
            step = stp.halfLowStep;
        end else if (!flags[4] && q.recTmr >= midInt) begin
            up = 1'b1;
            step = stp.halfMidStep;
        end else if (!flags[3] && q.recTmr >= topInt) begin
            up = 1'b1;
            step = stp.halfTopStep;
        end
    end else if (ctl.peakMode) begin
        if (ctl.halfOn && !flags[3]) begin
            up = 1'b1;
            step = stp.halfTopStep;
        end else if (!flags[1]) begin
            up = 1'b1;
            step = stp.pkRecovery;
        end
    end else if (!(ctl.blockInc &&
                   (flags[1] || (ctl.halfOn && flags[3])))) begin
        up = 1'b1;
        step = powerUnderStep;
    end
end

// ==========================================================================
// status pins and register read
assign pg = pinPair(psel.innerPair, inner, outer)
          | pinPair(psel.lowerPair, flags[1], flags[3])
          | pinPair(psel.upperPair, flags[0], flags[2]);

assign status = {14'h0, flags, inner, outer, q.win, q.filt[0], q.gain};
assign aIdx = apbReq.paddr[7:2];
assign aAligned = apbReq.paddr[1:0] == 2'b00;
assign mapped = aAligned && aIdx <= agc_pkg::IDX_STATUS;

always_comb begin
    if (!aAligned) begin
        rd = 32'h0;
    end else if (aIdx < agc_pkg::NREG) begin
        rd = q.regs[aIdx[3:0]];
    end else if (aIdx == agc_pkg::IDX_STATUS) begin
        rd = status;
    end else begin
        rd = 32'h0;
    end
end

// ==========================================================================
// next state
always_comb begin
    d = q;
    d.gainChg = 1'b0;
    d.sync = {q.sync[1:0], {peakLowerHit, peakUpperHit, rxEnable}};
    for (int k = 0; k < 3; k++) begin
        if (q.sync[1][k] == q.sync[2][k]) begin
            d.filt[k] = q.sync[2][k];
        end
    end
    rise = d.filt & ~q.filt;
    hits = {ovl & {4{ctl.halfOn}}, rise[2:1]};
    for (int k = 0; k < 6; k++) begin
        d.cnt[k] = satInc(q.cnt[k], hits[k]);
    end
    if (q.recTmr != 30'h3fff_ffff) begin
        d.recTmr = q.recTmr + 30'h1;
    end
    if (q.period != 22'h0) begin
        d.period = q.period - 22'h1;
    end
    // tdd power window
    if (!ctl.tddOn) begin
        d.win = q.filt[0];
    end else if (q.tddWait) begin
        if (q.tddCnt == 16'h0) begin
            d.tddWait = 1'b0;
            d.win = 1'b1;
            d.tddCnt = q.regs[agc_pkg::IDX_TDD][31:16];
        end else begin
            d.tddCnt = q.tddCnt - 16'h1;
        end
    end else if (q.win && q.tddCnt != 16'h0) begin
        d.tddCnt = q.tddCnt - 16'h1;
        if (q.tddCnt == 16'h1) begin
            d.win = 1'b0;
        end
    end
    if (q.win && powerValid) begin
        d.power = powerLevel;
        d.havePwr = 1'b1;
    end
    if (expire) begin
        d.period = q.regs[agc_pkg::IDX_PERIOD][21:0];
        d.cnt = '0;
        d.havePwr = 1'b0;
        if (ctl.tddOn && !q.tddWait && q.tddCnt == 16'h0) begin
            d.win = 1'b0;
        end
        if (atk || up) begin
            d.gain = stepGain(q.gain, step, up, gcfg.minIdx, gcfg.maxIdx);
            d.gainChg = d.gain != q.gain;
        end
        if (d.gainChg) begin
            d.recTmr = 30'h0;
        end
    end
    if (rise[0]) begin
        d.period = q.regs[agc_pkg::IDX_PERIOD][21:0];
        d.cnt = '0;
        d.tddWait = ctl.tddOn;
        d.tddCnt = q.regs[agc_pkg::IDX_TDD][15:0];
        d.win = 1'b0;
        d.recTmr = 30'h0;
    end
    if (!d.filt[0]) begin
        d.cnt = '0;
        d.win = 1'b0;
        d.tddWait = 1'b0;
        d.havePwr = 1'b0;
    end
    d.gOut = pg[15:0];
    d.gOe = pg[31:16];
    if (apbReq.psel && !apbReq.penable) begin
        d.rdata = rd;
    end
    if (apbReq.psel && apbReq.penable && apbReq.pwrite && aAligned &&
        aIdx < agc_pkg::NREG) begin
        d.regs[aIdx[3:0]] = apbReq.pwdata;
    end
end

always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
        q <= ST_RST;
    end else begin
        q <= d;
    end
end

// ==========================================================================
// outputs
assign prdata = q.rdata;
assign pready = apbReq.psel && apbReq.penable;
assign pslverr = pready && !mapped;
assign peakUpperLevel = pk.upperLevel;
assign peakLowerLevel = pk.lowerLevel;
assign powerWindow = q.win;
assign gainIndex = q.gain;
assign gainChange = q.gainChg;
assign gpioPins = '{out: q.gOut, oe: q.gOe};

// ==========================================================================
// checks
default clocking @(posedge clock); endclocking
default disable iff (rst);

sequence s_tdd_armed;
    ctl.tddOn && q.tddWait && q.tddCnt == 16'h0 && d.filt[0];
endsequence

sequence s_tdd_open;
    q.win && !q.tddWait;
endsequence

a_tdd_start: assert property (s_tdd_armed |=> s_tdd_open)
    else $error("tdd window did not open after delay");

a_period_reload: assert property ((expire && !rise[0] &&
    d.filt[0]) |=> q.period == $past(q.regs[agc_pkg::IDX_PERIOD][21:0])
    && q.cnt == '0)
    else $error("period not reloaded or detectors not cleared");

a_peak_attack: assert property ((expire && !rise[0] && flags[0] &&
    {1'b0, q.gain} >= {1'b0, gcfg.minIdx} + {4'h0, stp.pkAttack}) |=>
    q.gain == $past(q.gain) - {3'h0, $past(stp.pkAttack)})
    else $error("peak attack step not applied");

a_attack_wins: assert property ((expire && !rise[0] && atk &&
    q.gain >= gcfg.minIdx) |=> q.gain <= $past(q.gain) && !$past(up))
    else $error("gain rose during an attack period");

a_block_inc: assert property ((expire && !atk && !ctl.peakMode &&
    ctl.blockInc && flags[1] && !rise[0]) |=> $stable(q.gain))
    else $error("blocked gain increase happened");

a_gpio_pair: assert property ((psel.innerPair == 4'h9 &&
    psel.lowerPair < 4'h8 && psel.upperPair < 4'h8) |=>
    q.gOe[15:14] == 2'b11 && q.gOut[14] == $past(inner) &&
    q.gOut[15] == $past(outer))
    else $error("power status not on pins 14 and 15");

endmodule

//--- tb/agc_bb_model.sv
// baseband side model: samples the status pins every clock
`timescale 1ns/10ps
module agc_bb_model (
    input  wire logic               clock, // agc clock
    input  wire agc_pkg::agc_pins_t pins,  // status pin drive
    output logic [15:0]             seen   // pin levels as sampled
);
    // undriven pins read low through pull-downs
    always_ff @(posedge clock) seen <= pins.out & pins.oe;
endmodule

//--- tb/agc_decision_test.sv
// self-checking testbench of the agc decision block
`timescale 1ns/10ps
module agc_decision_test;
    logic                  clock = 1'b0;
    logic                  rst = 1'b1;
    agc_pkg::agc_apb_req_t req = '0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  rxOn = 1'b0;
    logic                  upHit = 1'b0;
    logic                  loHit = 1'b0;
    logic [4:0]            pUp = 5'h00;
    agc_pkg::agc_iq_t      iqIn = '0;
    logic                  win;
    logic [5:0]            upLvl;
    logic [5:0]            loLvl;
    logic                  pValid = 1'b0;
    logic [6:0]            pLevel = 7'h00;
    logic [7:0]            gain;
    logic                  gChg;
    agc_pkg::agc_pins_t    pins;
    logic [15:0]           seen;
    logic [31:0]           rd;
    logic                  err;
    int                    n_fail = 0;
    int                    compares = 0;

    agc_decision dut (
        .clock          (clock),
        .rst            (rst),
        .apbReq         (req),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .rxEnable       (rxOn),
        .peakUpperHit   (upHit),
        .peakLowerHit   (loHit),
        .iq             (iqIn),
        .powerValid     (pValid),
        .powerLevel     (pLevel),
        .powerUnderStep (pUp),
        .peakUpperLevel (upLvl),
        .peakLowerLevel (loLvl),
        .powerWindow    (win),
        .gainIndex      (gain),
        .gainChange     (gChg),
        .gpioPins       (pins)
    );

    agc_bb_model bb (
        .clock (clock),
        .pins  (pins),
        .seen  (seen)
    );

    initial begin
        forever #20 clock = ~clock;
    end

    // ======================================================================
    // shared tasks
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic hang();
        n_fail++;
        complete_run();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // setup, then access until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock);
        req.penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        req <= '0;
        if (n >= 20) hang();
    endtask

    task automatic gwait(input logic [7:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (gChg !== 1'b1 && n < 300);
        if (n >= 300) hang();
        chk({24'h0, gain}, {24'h0, exp});
    endtask

    // ======================================================================
    // scenarios
    task automatic t_regs();
        for (int i = 0; i < 13; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, agc_pkg::RST_REGS[i]);
        end
        apb(1'b0, 8'h38, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_pins();
        apb(1'b1, 8'h2c, 32'h9);
        repeat (2) @(posedge clock);
        #1;
        chk({16'h0, pins.oe}, 32'h0000_c000);
        $display("test pins done");
    endtask

    task automatic t_power();
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'd20);
        apb(1'b1, 8'h0c, 32'h0008_1187);
        @(posedge clock);
        pLevel <= 7'd2;
        pValid <= 1'b1;
        rxOn <= 1'b1;
        gwait(8'hf7);
        repeat (3) @(posedge clock);
        pLevel <= 7'd5;
        #1;
        chk({16'h0, seen}, 32'h0000_c000);
        gwait(8'hf5);
        repeat (3) @(posedge clock);
        #1;
        chk({16'h0, seen}, 32'h0000_4000);
        @(posedge clock);
        rxOn <= 1'b0;
        $display("test power done");
    endtask

    task automatic t_peak();
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h04, 32'd40);
        apb(1'b1, 8'h10, 32'h0203_0a8c);
        apb(1'b1, 8'h14, 32'h0c41_0862);
        chk({26'h0, upLvl}, 32'd42);
        chk({26'h0, loLvl}, 32'd12);
        @(posedge clock);
        rxOn <= 1'b1;
        gwait(8'hf8);
        repeat (3) begin
            repeat (4) @(posedge clock);
            upHit <= 1'b1;
            repeat (4) @(posedge clock);
            upHit <= 1'b0;
        end
        gwait(8'hf6);
        $display("test peak done");
    endtask

    // window opens delay+1 edges after the filtered rise, 4 edges in
    task automatic t_tdd();
        int first;
        int cnt;
        first = 0;
        cnt = 0;
        apb(1'b1, 8'h00, 32'h20);
        apb(1'b1, 8'h08, 32'h0005_0003);
        @(posedge clock);
        rxOn <= 1'b1;
        for (int i = 1; i <= 20; i++) begin
            @(posedge clock);
            #1;
            if (win === 1'b1) begin
                cnt++;
                if (first == 0) begin
                    first = i;
                end
            end
        end
        chk(32'(first), 32'd8);
        chk(32'(cnt), 32'd5);
        @(posedge clock);
        rxOn <= 1'b0;
        $display("test tdd done");
    endtask

    task automatic t_half();
        int n;
        n = 0;
        @(posedge clock);
        rxOn <= 1'b0;
        apb(1'b1, 8'h00, 32'h5);
        apb(1'b1, 8'h1c, 32'h0040_16c2);
        apb(1'b1, 8'h2c, 32'h100);
        @(posedge clock);
        rxOn <= 1'b1;
        iqIn <= '{1'b1, 16'sh4000, 16'sh0000};
        while (seen[7] !== 1'b1 && n < 60) begin
            @(posedge clock);
            n++;
        end
        chk({16'h0, seen}, 32'h0000_0080);
        gwait(8'hf4);
        @(posedge clock);
        iqIn <= '0;
        gwait(8'hf6);
        @(posedge clock);
        rxOn <= 1'b0;
        $display("test half done");
    endtask

    task automatic t_block();
        repeat (4) @(posedge clock);
        pLevel <= 7'd20;
        pUp <= 5'd3;
        apb(1'b1, 8'h00, 32'h10);
        @(posedge clock);
        rxOn <= 1'b1;
        repeat (12) begin
            repeat (4) @(posedge clock);
            loHit <= 1'b1;
            repeat (4) @(posedge clock);
            loHit <= 1'b0;
        end
        chk({24'h0, gain}, 32'h0000_00f6);
        gwait(8'hf9);
        $display("test block done");
    endtask

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_pins();
        t_tdd();
        t_power();
        t_peak();
        t_half();
        t_block();
        complete_run();
    end
endmodule
